// ---- verilog/tps_map.svh ----
// tps_map.svh: register offsets, field positions and reset values for the
// counter clock and prescaler select block.
// assumes: included by bare name from the package and the design files.
`ifndef TPS_MAP_SVH
`define TPS_MAP_SVH

`define TPS_OFF_OPTION     12'h000
`define TPS_OFF_COUNT      12'h004
`define TPS_OFF_WDT_CLEAR  12'h008
`define TPS_OFF_IRQ_STATUS 12'h00C
`define TPS_OFF_IRQ_MASK   12'h010
`define TPS_OFF_WDT_COUNT  12'h014

`define TPS_BIT_PULLUP_DIS 7
`define TPS_BIT_IRQ_EDGE   6
`define TPS_BIT_CLK_SRC    5
`define TPS_BIT_EDGE_SEL   4
`define TPS_BIT_PS_ASSIGN  3
`define TPS_PS_RATIO_HI    2
`define TPS_PS_RATIO_LO    0

`define TPS_BIT_IRQ_CNT_OVF 0
`define TPS_BIT_IRQ_WDT_OVF 1

`define TPS_OPTION_RESET   8'hFF
`define TPS_IRQ_MASK_RESET 2'h0

`define TPS_WDT_CLEAR_KEY  32'h0000_0001

`endif

// ---- verilog/tps_pkg.sv ----
// tps_pkg.sv: types shared by the counter clock and prescaler design.
// assumes: tps_map.svh on the include path.
`include "tps_map.svh"

package tps_pkg;

    typedef logic [7:0] tps_byte_t;
    typedef logic [2:0] tps_ratio_t;

    typedef enum logic [1:0] {
        TPS_BUS_IDLE  = 2'b00,
        TPS_BUS_WRITE = 2'b01,
        TPS_BUS_READ  = 2'b10
    } tps_bus_phase_t;

endpackage

// ---- verilog/tps_edge_pick.sv ----
// tps_edge_pick.sv: picks the count source and turns it into a one-cycle
// tick per selected edge.
// assumes: ext pin already synchronous to the clock.
`timescale 1ns/1ns
`default_nettype none

module tps_edge_pick (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic ext_pin,
    input  wire logic use_ext,
    input  wire logic fall_edge,
    output logic      tick
);
    import tps_pkg::*;

    typedef struct packed {
        logic pin_q;
        logic tick;
    } tps_edge_state_t;

    tps_edge_state_t st;
    tps_edge_state_t next_st;

    always_comb begin
        next_st       = st;
        next_st.pin_q = ext_pin;
        if (use_ext) begin
            if (fall_edge) begin
                next_st.tick = st.pin_q & ~ext_pin;
            end else begin
                next_st.tick = ~st.pin_q & ext_pin;
            end
        end else begin
            next_st.tick = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick = st.tick;

endmodule

`default_nettype wire

// ---- verilog/tps_prescaler.sv ----
// tps_prescaler.sv: the one shared 8-bit prescaler, not visible to software.
// assumes: clear has priority over a source tick in the same cycle.
`timescale 1ns/1ns
`default_nettype none

module tps_prescaler #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic             tick_in,
    input  wire logic             clear,
    input  wire tps_pkg::tps_ratio_t ratio,
    input  wire logic             to_wdt,
    output logic                  tick_out
);
    import tps_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic             tick;
    } tps_ps_state_t;

    tps_ps_state_t st;
    tps_ps_state_t next_st;
    logic [WIDTH-1:0] inc;
    logic [3:0]       tap;
    logic [2:0]       idx;

    // counter divides by 2^(code+1), watchdog by 2^code; 1:1 is pass-through
    always_comb begin
        tap  = to_wdt ? {1'b0, ratio} : ({1'b0, ratio} + 4'h1);
        inc  = st.count + {{(WIDTH-1){1'b0}}, 1'b1};
        idx  = tap[2:0] - 3'h1;
        next_st      = st;
        next_st.tick = 1'b0;
        if (clear) begin
            next_st.count = '0;
        end else if (tick_in) begin
            if (tap == 4'h0) begin
                next_st.tick = 1'b1;
            end else begin
                next_st.count = inc;
                // carry out of the tapped bits: a full period after a clear
                next_st.tick  = st.count[idx] & ~inc[idx];
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick_out = st.tick;

endmodule

`default_nettype wire

// ---- verilog/tps_timer.sv ----
// tps_timer.sv: 8-bit counter with clock source, edge and shared prescaler
// selection, an AHB-Lite register slave and a level interrupt.
// assumes: one clock; pin input synchronous; single word transfers only.
//
// How it works
// - clock-source bit 1 counts the external pin, 0 the cycle clock.
// - edge-select bit 1 counts falling pin edges, 0 rising ones.
// - assign bit 1 gives the prescaler to the watchdog, 0 to the counter; the other runs undivided.
// - ratio code n divides the counter by 2^(n+1) and the watchdog by 2^n.
// - there is a single prescaler, owned by one user, hidden from software.
// - a counter write clears the prescaler when the counter owns it.
// - a watchdog clear clears watchdog and prescaler when the watchdog owns it.
//
// Register access over AHB-Lite and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "tps_map.svh"

module tps_timer (
    input  wire logic        SYS_CLK,
    input  wire logic        ARST_N,
    input  wire logic        COUNTER_EXT_CLOCK_PIN,
    input  wire logic        HSEL,
    input  wire logic [11:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    output logic             IRQ,
    output logic             WATCHDOG_TIMEOUT,
    output logic             PORT_PULLUP_DISABLE,
    output logic             EXT_IRQ_EDGE_SELECT
);
    import tps_pkg::*;

    typedef struct packed {
        tps_bus_phase_t phase;
        logic [11:0]    addr;
        logic [31:0]    rdata;
        tps_byte_t      option;
        tps_byte_t      count;
        tps_byte_t      wdt;
        logic [1:0]     irq_status;
        logic [1:0]     irq_mask;
        logic           irq;
        logic           wdt_timeout;
        logic           ps_clear;
    } tps_top_state_t;

    tps_top_state_t st;
    tps_top_state_t next_st;

    logic       src_tick;
    logic       ps_in;
    logic       ps_tick;
    logic       to_wdt;
    logic       cnt_step;
    logic       wdt_step;
    logic       wdt_src;
    logic       take;
    logic       wr_cnt;
    logic       wr_wdt_clr;
    logic [1:0] ev;
    tps_byte_t  cnt_inc;
    tps_byte_t  wdt_inc;

    assign to_wdt = st.option[`TPS_BIT_PS_ASSIGN];

    tps_edge_pick u_edge (
        .clk       (SYS_CLK),
        .arst_n    (ARST_N),
        .ext_pin   (COUNTER_EXT_CLOCK_PIN),
        .use_ext   (st.option[`TPS_BIT_CLK_SRC]),
        .fall_edge (st.option[`TPS_BIT_EDGE_SEL]),
        .tick      (src_tick)
    );

    // watchdog base tick is the cycle clock, stand-in for its own oscillator
    assign wdt_src = 1'b1;
    // one prescaler instance, input muxed to its owner only
    assign ps_in   = to_wdt ? wdt_src : src_tick;

    tps_prescaler #(
        .WIDTH (8)
    ) u_ps (
        .clk      (SYS_CLK),
        .arst_n   (ARST_N),
        .tick_in  (ps_in),
        .clear    (st.ps_clear),
        .ratio    (st.option[`TPS_PS_RATIO_HI:`TPS_PS_RATIO_LO]),
        .to_wdt   (to_wdt),
        .tick_out (ps_tick)
    );

    always_comb begin
        take       = HSEL & HREADY & HTRANS[1];
        cnt_step   = to_wdt ? src_tick : ps_tick;
        wdt_step   = to_wdt ? ps_tick : wdt_src;
        cnt_inc    = st.count + 8'h01;
        wdt_inc    = st.wdt + 8'h01;
        wr_cnt     = (st.phase == TPS_BUS_WRITE) && (st.addr == `TPS_OFF_COUNT);
        wr_wdt_clr = (st.phase == TPS_BUS_WRITE) &&
                     (st.addr == `TPS_OFF_WDT_CLEAR) &&
                     (HWDATA == `TPS_WDT_CLEAR_KEY);
        ev         = 2'b00;

        next_st             = st;
        next_st.ps_clear    = 1'b0;
        next_st.wdt_timeout = 1'b0;

        if (cnt_step) begin
            next_st.count = cnt_inc;
            ev[`TPS_BIT_IRQ_CNT_OVF] = (st.count == 8'hFF);
        end
        if (wdt_step) begin
            next_st.wdt = wdt_inc;
            if (st.wdt == 8'hFF) begin
                ev[`TPS_BIT_IRQ_WDT_OVF] = 1'b1;
                next_st.wdt_timeout      = 1'b1;
            end
        end

        // data phase: writes land here, write beats the count step
        if (st.phase == TPS_BUS_WRITE) begin
            unique case (st.addr)
                `TPS_OFF_OPTION: next_st.option = HWDATA[7:0];
                `TPS_OFF_COUNT: next_st.count = HWDATA[7:0];
                `TPS_OFF_IRQ_STATUS:
                    next_st.irq_status = st.irq_status & ~HWDATA[1:0];
                `TPS_OFF_IRQ_MASK: next_st.irq_mask = HWDATA[1:0];
                default: ;
            endcase
        end
        // assignment bit is left alone, only the prescaler count drops
        if (wr_cnt && !to_wdt) begin
            next_st.ps_clear = 1'b1;
        end
        if (wr_wdt_clr) begin
            next_st.wdt = 8'h00;
            if (to_wdt) begin
                next_st.ps_clear = 1'b1;
            end
        end
        // set wins over a same-cycle clear
        next_st.irq_status = next_st.irq_status | ev;
        next_st.irq = |(next_st.irq_status & next_st.irq_mask);

        next_st.phase = TPS_BUS_IDLE;
        next_st.rdata = 32'h0000_0000;
        if (take) begin
            next_st.addr  = HADDR;
            next_st.phase = HWRITE ? TPS_BUS_WRITE : TPS_BUS_READ;
            // read data registered in the address phase, held in data phase
            if (!HWRITE) begin
                unique case (HADDR)
                    `TPS_OFF_OPTION:     next_st.rdata = {24'h0, st.option};
                    `TPS_OFF_COUNT:      next_st.rdata = {24'h0, st.count};
                    `TPS_OFF_IRQ_STATUS: next_st.rdata = {30'h0, st.irq_status};
                    `TPS_OFF_IRQ_MASK:   next_st.rdata = {30'h0, st.irq_mask};
                    `TPS_OFF_WDT_COUNT:  next_st.rdata = {24'h0, st.wdt};
                    default:             next_st.rdata = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            st            <= '0;
            st.option     <= `TPS_OPTION_RESET;
            st.irq_mask   <= `TPS_IRQ_MASK_RESET;
        end else begin
            st <= next_st;
        end
    end

    // software keeps the clear-then-reassign order; no hardware guard
    assign HRDATA              = st.rdata;
    assign HREADYOUT           = 1'b1;
    assign HRESP               = 1'b0;
    assign IRQ                 = st.irq;
    assign WATCHDOG_TIMEOUT    = st.wdt_timeout;
    assign PORT_PULLUP_DISABLE = st.option[`TPS_BIT_PULLUP_DIS];
    assign EXT_IRQ_EDGE_SELECT = st.option[`TPS_BIT_IRQ_EDGE];

endmodule

`default_nettype wire

// ---- dv/tps_ext_src.sv ----
// tps_ext_src.sv: model of the source driving the external count pin.
// assumes: the block samples the pin on its own clock.
`timescale 1ns/1ns
`default_nettype none

module tps_ext_src (
    input  wire logic clk,
    output logic      pin
);
    initial pin = 1'b0;

    // four cycles per level, slower than any pin synchroniser
    task automatic toggle(input int k);
        repeat (k) begin
            repeat (4) @(posedge clk);
            pin <= ~pin;
        end
        // pin then stands still until the next burst
        repeat (6) @(posedge clk);
    endtask
endmodule

`default_nettype wire

// ---- dv/tps_timer_props.sv ----
// tps_timer_props.sv: port-level checker for the timer block, bound below.
// assumes: one clock domain, zero-wait AHB-Lite slave.
`timescale 1ns/1ns
`default_nettype none
`include "tps_map.svh"

module tps_timer_props (
    input  wire logic        SYS_CLK,
    input  wire logic        ARST_N,
    input  wire logic        HSEL,
    input  wire logic [11:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    input  wire logic [31:0] HRDATA,
    input  wire logic        HREADYOUT,
    input  wire logic        HRESP,
    input  wire logic        IRQ,
    input  wire logic        WATCHDOG_TIMEOUT,
    input  wire logic        PORT_PULLUP_DISABLE,
    input  wire logic        EXT_IRQ_EDGE_SELECT
);
    logic        rd_ph;
    logic        wr_ph;
    logic [11:0] ph_a;
    logic [1:0]  hw_q;
    logic [1:0]  mask_q;
    logic [8:0]  gap;
    logic        seen;
    wire  logic  take = HSEL && HREADY && HTRANS[1];

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rd_ph  <= 1'b0;
            wr_ph  <= 1'b0;
            ph_a   <= 12'h000;
            hw_q   <= 2'h0;
            mask_q <= 2'h0;
            gap    <= 9'h000;
            seen   <= 1'b0;
        end else begin
            rd_ph <= take && !HWRITE;
            wr_ph <= take && HWRITE;
            ph_a  <= HADDR;
            hw_q  <= HWDATA[7:6];
            if (wr_ph && ph_a == `TPS_OFF_IRQ_MASK) begin
                mask_q <= HWDATA[1:0];
            end
            // saturates, only a lower bound matters
            gap  <= WATCHDOG_TIMEOUT ? 9'h000 : gap + {8'h00, gap != 9'h1FF};
            seen <= seen | WATCHDOG_TIMEOUT;
        end
    end

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!ARST_N);

    property p_okay; HREADYOUT && !HRESP; endproperty
    a_okay: assert property (p_okay) else $error("slave not ready or error");
    property p_rd_idle; !rd_ph |-> HRDATA == 32'h0000_0000; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside phase");
    property p_rd_hi; rd_ph |-> HRDATA[31:8] == 24'h00_0000; endproperty
    a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
    property p_opt;
        wr_ph && ph_a == `TPS_OFF_OPTION |=>
            {PORT_PULLUP_DISABLE, EXT_IRQ_EDGE_SELECT} == hw_q;
    endproperty
    a_opt: assert property (p_opt) else $error("option bits not taken");
    property p_rst;
        $rose(ARST_N) |-> PORT_PULLUP_DISABLE && EXT_IRQ_EDGE_SELECT;
    endproperty
    a_rst: assert property (p_rst) else $error("option reset value wrong");
    property p_wdt_one; WATCHDOG_TIMEOUT |=> !WATCHDOG_TIMEOUT; endproperty
    a_wdt_one: assert property (p_wdt_one) else $error("timeout too long");
    property p_wdt_gap; WATCHDOG_TIMEOUT && seen |-> gap >= 9'h0FF; endproperty
    a_wdt_gap: assert property (p_wdt_gap) else $error("watchdog too fast");
    property p_irq_off;
        mask_q == 2'h0 && $past(mask_q) == 2'h0 |-> !IRQ;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("masked irq seen");
    property p_irq_on; WATCHDOG_TIMEOUT && mask_q[1] |-> ##[0:3] IRQ; endproperty
    a_irq_on: assert property (p_irq_on) else $error("irq not raised");
endmodule

bind tps_timer tps_timer_props u_props (
    .SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .IRQ(IRQ),
    .WATCHDOG_TIMEOUT(WATCHDOG_TIMEOUT),
    .PORT_PULLUP_DISABLE(PORT_PULLUP_DISABLE),
    .EXT_IRQ_EDGE_SELECT(EXT_IRQ_EDGE_SELECT)
);

`default_nettype wire

// ---- dv/tb_top.sv ----
// tb_top.sv: self-checking bench for the timer clock and prescaler block.
// assumes: zero-wait AHB-Lite slave; pin source model beside the design.
`timescale 1ns/1ns
`default_nettype none
`include "tps_map.svh"
`define CHK(nm, e, s) begin \
    samples_checked++; \
    if ((s) !== (e)) begin \
        err_count++; \
        $display("wrong value %s exp %h got %h", nm, e, s); \
    end \
end

module tb_top;
    logic        sys_clk = 1'b0;
    logic        arst_n  = 1'b0;
    logic        hsel    = 1'b0;
    logic        hwrite  = 1'b0;
    logic [1:0]  htrans  = 2'b00;
    logic [11:0] haddr   = 12'h000;
    logic [31:0] hwdata  = 32'h0000_0000;
    logic [31:0] hrdata;
    logic [31:0] rd;
    wire  logic  hreadyout;
    wire  logic  hresp;
    wire  logic  irq;
    wire  logic  wdt_to;
    wire  logic  pud;
    wire  logic  eie;
    wire  logic  pin;
    int          err_count = 0;
    int          samples_checked = 0;

    tps_timer dut (
        .SYS_CLK(sys_clk), .ARST_N(arst_n), .COUNTER_EXT_CLOCK_PIN(pin),
        .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hreadyout),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .IRQ(irq),
        .WATCHDOG_TIMEOUT(wdt_to), .PORT_PULLUP_DISABLE(pud),
        .EXT_IRQ_EDGE_SELECT(eie)
    );
    tps_ext_src src (.clk(sys_clk), .pin(pin));

    initial forever #5 sys_clk = ~sys_clk;

    task automatic end_of_test;
        if (err_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic step_rdy;
        int n;
        n = 0;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 40) begin
                err_count++;
                end_of_test;
            end
            @(posedge sys_clk);
        end
    endtask

    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= w;
        step_rdy;
        htrans <= 2'b00;
        hwdata <= d;
        step_rdy;
        rd = hrdata;
    endtask

    // counter advance over 8 prescaler periods, sampled an exact span apart
    task automatic t_rate(input logic [7:0] opt, input int div);
        logic [7:0] c0;
        bus(1'b1, `TPS_OFF_COUNT, '0);
        bus(1'b1, `TPS_OFF_OPTION, {24'h00_0000, opt});
        // let the old ratio and source tick drain before the window
        repeat (4) @(posedge sys_clk);
        bus(1'b0, `TPS_OFF_COUNT, '0);
        c0 = rd[7:0];
        repeat (8 * div - 2) @(posedge sys_clk);
        bus(1'b0, `TPS_OFF_COUNT, '0);
        `CHK("count step", 8'h08, rd[7:0] - c0)
    endtask

    task automatic t_ext(input logic [7:0] opt);
        logic [7:0] c0;
        logic [7:0] e;
        bus(1'b1, `TPS_OFF_OPTION, {24'h00_0000, opt});
        // a tick from the previous source may still be in flight
        repeat (2) @(posedge sys_clk);
        bus(1'b0, `TPS_OFF_COUNT, '0);
        c0 = rd[7:0];
        e = (pin ^ opt[4]) ? 8'h02 : 8'h03;
        src.toggle(5);
        bus(1'b0, `TPS_OFF_COUNT, '0);
        `CHK("pin count", e, rd[7:0] - c0)
    endtask

    task automatic t_clr;
        bus(1'b1, `TPS_OFF_OPTION, 32'h0000_0087);
        bus(1'b1, `TPS_OFF_COUNT, 32'h0000_0005);
        repeat (200) @(posedge sys_clk);
        bus(1'b1, `TPS_OFF_COUNT, 32'h0000_0005);
        repeat (200) @(posedge sys_clk);
        bus(1'b0, `TPS_OFF_COUNT, '0);
        `CHK("count held", 8'h05, rd[7:0])
        bus(1'b0, `TPS_OFF_OPTION, '0);
        `CHK("assign kept", 32'h0000_0087, rd)
        `CHK("pullup bit", 1'b1, pud)
        `CHK("irq edge bit", 1'b0, eie)
    endtask

    task automatic t_wdt;
        bus(1'b1, `TPS_OFF_COUNT, '0);
        bus(1'b1, `TPS_OFF_OPTION, 32'h0000_000F);
        bus(1'b1, `TPS_OFF_WDT_CLEAR, `TPS_WDT_CLEAR_KEY);
        repeat (100) @(posedge sys_clk);
        bus(1'b1, `TPS_OFF_WDT_CLEAR, `TPS_WDT_CLEAR_KEY);
        repeat (100) @(posedge sys_clk);
        bus(1'b0, `TPS_OFF_WDT_COUNT, '0);
        `CHK("wdt count", 8'h00, rd[7:0])
    endtask

    task automatic t_irq;
        int n;
        bus(1'b1, `TPS_OFF_IRQ_STATUS, 32'h0000_0003);
        bus(1'b1, `TPS_OFF_COUNT, 32'h0000_00F0);
        bus(1'b0, `TPS_OFF_IRQ_STATUS, '0);
        `CHK("ovf early", 1'b0, rd[0])
        repeat (20) @(posedge sys_clk);
        bus(1'b0, `TPS_OFF_COUNT, '0);
        `CHK("wrapped", 3'h0, rd[7:5])
        bus(1'b0, `TPS_OFF_IRQ_STATUS, '0);
        `CHK("ovf flag", 1'b1, rd[0])
        `CHK("irq masked", 1'b0, irq)
        bus(1'b1, `TPS_OFF_IRQ_MASK, 32'h0000_0001);
        repeat (2) @(posedge sys_clk);
        `CHK("irq on", 1'b1, irq)
        bus(1'b1, `TPS_OFF_IRQ_STATUS, 32'h0000_0001);
        repeat (2) @(posedge sys_clk);
        `CHK("irq cleared", 1'b0, irq)
        // watchdog now undivided, wraps every 256 cycles
        bus(1'b1, `TPS_OFF_OPTION, '0);
        bus(1'b1, `TPS_OFF_IRQ_MASK, 32'h0000_0002);
        n = 0;
        while (wdt_to !== 1'b1 && n < 300) begin
            @(posedge sys_clk);
            n++;
        end
        `CHK("wdt pulse", 1'b1, wdt_to)
        `CHK("wdt irq", 1'b1, irq)
        @(posedge sys_clk);
        `CHK("wdt pulse end", 1'b0, wdt_to)
        bus(1'b1, `TPS_OFF_IRQ_MASK, '0);
    endtask

    initial begin
        repeat (6) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        bus(1'b0, `TPS_OFF_OPTION, '0);
        `CHK("option reset", 32'h0000_00FF, rd)
        `CHK("pullup reset", 1'b1, pud)
        `CHK("edge reset", 1'b1, eie)
        `CHK("okay resp", 1'b0, hresp)
        bus(1'b0, 12'h0FC, '0);
        `CHK("unmapped", 32'h0000_0000, rd)
        bus(1'b0, `TPS_OFF_IRQ_MASK, '0);
        `CHK("mask reset", 32'h0000_0000, rd)
        for (int c = 0; c < 8; c++) begin
            t_rate({5'h00, c[2:0]}, 2 ** (c + 1));
        end
        t_rate(8'h08, 1);
        t_ext(8'h28);
        t_ext(8'h38);
        t_ext(8'h38);
        t_ext(8'h28);
        t_clr;
        t_wdt;
        t_irq;
        end_of_test;
    end
endmodule

`default_nettype wire
